// >>> tss_slave.sv
// two-wire slave state engine with an axi4-lite register port
// Operation
// - general-call data acked gives 0x90, ack follows enable
// - general-call data nacked gives 0x98, then unaddressed
// - stop or restart while addressed as receiver gives 0xA0
// - unaddressed recognition per enables; start queued if requested
// - address bits 7:1 match, bit 0 enables general call
// - direction bit one selects transmit, else receive
// - after address, flag set with valid status
// - arbitration lost then read address gives 0xB0
// - ack enable cleared: last byte, then 0xC0/0xC8
// - after last byte unaddressed, data line released
// - ack enable zero ignores own address, keeps monitoring
// - in sleep, address match still acked and wakes
// - after wake, clock held low until flag cleared
// - data register keeps no bus byte on wake
// - own read address acked gives 0xA8, then transmit
// - transmitted byte acked gives 0xB8, next byte sent
// - own write address acked gives 0x60, receive
`timescale 1ns/10ps
module tss_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // two-wire pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // system side
  input wire logic arb_lost,
  input wire logic sleep_req,
  output logic wake,
  output logic start_when_free
);
  logic aw_got, w_got;
  logic [3:0] waddr;
  logic [7:0] wdat;
  logic wstb;
  logic [7:0] own, data_reg, status, sh, tx;
  logic ack_en, sta, sto, wc, en, ie, flag;
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  tss_pkg::tss_mode_t mode;
  logic [3:0] bi;
  logic gc, rd, ackd, last, mack, busy;
  logic wr_go, wr_ctrl, wr_data, clr;
  logic rise, fall, start, stop, is_own, is_gc, match;

  // offsets that answer okay on the bus
  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == tss_pkg::OFS_ADDR) || (a == tss_pkg::OFS_CTRL) ||
             (a == tss_pkg::OFS_STAT) || (a == tss_pkg::OFS_DATA);
  endfunction

  // write decode, only byte lane 0 carries data
  assign wr_go = aw_got && w_got && !bvalid;
  assign wr_ctrl = wr_go && wstb && (waddr == tss_pkg::OFS_CTRL);
  assign wr_data = wr_go && wstb && (waddr == tss_pkg::OFS_DATA);
  assign clr = wr_ctrl && wdat[tss_pkg::CB_INT];

  // write channels taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      bvalid <= 1'b0;
      bresp <= tss_pkg::RESP_OK;
      waddr <= 4'h0;
      wdat <= 8'h00;
      wstb <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_got <= 1'b1;
        waddr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_got <= 1'b1;
        wdat <= wdata[7:0];
        wstb <= wstrb[0];
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(waddr) ? tss_pkg::RESP_OK : tss_pkg::RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= tss_pkg::RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= mapped(araddr) ? tss_pkg::RESP_OK : tss_pkg::RESP_ERR;
      unique case (araddr)
        tss_pkg::OFS_ADDR: rdata <= {24'h00_0000, own};
        tss_pkg::OFS_CTRL: rdata <= {24'h00_0000, flag, ack_en, sta, sto, wc, en, 1'b0, ie};
        tss_pkg::OFS_STAT: rdata <= {24'h00_0000, flag ? status : tss_pkg::SC_NONE};
        tss_pkg::OFS_DATA: rdata <= {24'h00_0000, data_reg};
        default: rdata <= 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // software control bits; write collision when data written with the flag clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own <= tss_pkg::ADDR_RST;
      {ack_en, sta, sto, wc, en, ie} <= 6'h00;
    end else begin
      if (wr_go && wstb && (waddr == tss_pkg::OFS_ADDR))
        own <= wdat;
      if (wr_ctrl) begin
        ack_en <= wdat[tss_pkg::CB_ACK];
        sta <= wdat[tss_pkg::CB_STA];
        sto <= wdat[tss_pkg::CB_STO];
        en <= wdat[tss_pkg::CB_EN];
        ie <= wdat[tss_pkg::CB_IE];
      end
      if (wr_data)
        wc <= !flag;
    end
  end

  // pins are asynchronous: two flops before any use, third for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign rise = scl_s && !scl_p;
  assign fall = !scl_s && scl_p;
  assign start = scl_s && scl_p && sda_p && !sda_s;
  assign stop = scl_s && scl_p && !sda_p && sda_s;
  // recognition needs ack enable; general call only for write
  assign is_own = ack_en && (sh[7:1] == own[7:1]);
  assign is_gc = ack_en && own[0] && (sh[7:1] == 7'h00) && !sh[0];
  assign match = is_own || is_gc;

  // bus busy tracking and queued start request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      start_when_free <= 1'b0;
      wake <= 1'b0;
    end else begin
      if (start)
        busy <= 1'b1;
      else if (stop)
        busy <= 1'b0;
      start_when_free <= en && sta && !busy && !flag;
      // clock stays running here; sleep only gates wake reporting
      if (!sleep_req)
        wake <= 1'b0;
      else if (en && mode == tss_pkg::M_ADDR && fall && bi == tss_pkg::LAST_BIT && match)
        wake <= 1'b1;
    end
  end

  // frame engine: flag, status, data and pin drive share one owner
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= tss_pkg::M_IDLE;
      bi <= 4'h0;
      {sh, tx} <= 16'h0000;
      {gc, rd, ackd, last, mack} <= 5'h00;
      flag <= 1'b0;
      status <= tss_pkg::SC_NONE;
      data_reg <= tss_pkg::DATA_RST;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      if (wr_data && flag)
        data_reg <= wdat;
      // clearing the flag lets the clock go and, in transmit, loads the next byte
      if (clr) begin
        flag <= 1'b0;
        scl_oe <= 1'b0;
        if (mode == tss_pkg::M_TX && bi == 4'h0) begin
          tx <= data_reg;
          // the enable written with this clear decides, so one write ends it
          last <= !wdat[tss_pkg::CB_ACK];
          sda_oe <= !data_reg[7];
        end
      end
      if (!en) begin
        mode <= tss_pkg::M_IDLE;
        bi <= 4'h0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else if (start || stop) begin
        // set after a clear in the same cycle still wins
        if (mode == tss_pkg::M_RX) begin
          flag <= 1'b1;
          status <= tss_pkg::SC_STOP;
        end
        mode <= start ? tss_pkg::M_ADDR : tss_pkg::M_IDLE;
        // the scl fall that closes a start must not count as a bit; it wraps to 0
        bi <= start ? 4'hF : 4'h0;
        sda_oe <= 1'b0;
      end else begin
        if (rise && bi != tss_pkg::ACK_BIT)
          sh <= {sh[6:0], sda_s};
        if (rise && bi == tss_pkg::ACK_BIT)
          mack <= !sda_s;
        if (fall) begin
          bi <= (bi == tss_pkg::ACK_BIT) ? 4'h0 : 4'(bi + 4'h1);
          if (mode == tss_pkg::M_TX && bi < tss_pkg::LAST_BIT) begin
            tx <= {tx[6:0], 1'b1};
            sda_oe <= !tx[6];
          end
          if (bi == tss_pkg::LAST_BIT) begin
            unique case (mode)
              tss_pkg::M_ADDR: begin
                if (match) begin
                  sda_oe <= 1'b1;
                  gc <= !is_own;
                  rd <= sh[0];
                end else begin
                  mode <= tss_pkg::M_IDLE;
                end
              end
              tss_pkg::M_RX: begin
                sda_oe <= ack_en;
                ackd <= ack_en;
              end
              tss_pkg::M_TX: sda_oe <= 1'b0;
              tss_pkg::M_IDLE: sda_oe <= 1'b0;
            endcase
          end
          if (bi == tss_pkg::ACK_BIT && mode != tss_pkg::M_IDLE) begin
            sda_oe <= 1'b0;
            flag <= 1'b1;
            scl_oe <= 1'b1;
            unique case (mode)
              tss_pkg::M_ADDR: begin
                // address byte never reaches data_reg
                mode <= rd ? tss_pkg::M_TX : tss_pkg::M_RX;
                if (rd)
                  status <= arb_lost ? tss_pkg::SC_ARB_R : tss_pkg::SC_OWN_R;
                else if (gc)
                  status <= arb_lost ? tss_pkg::SC_ARB_GC : tss_pkg::SC_GC_W;
                else
                  status <= arb_lost ? tss_pkg::SC_ARB_W : tss_pkg::SC_OWN_W;
              end
              tss_pkg::M_RX: begin
                data_reg <= sh;
                if (gc)
                  status <= ackd ? tss_pkg::SC_GC_ACK : tss_pkg::SC_GC_NACK;
                else
                  status <= ackd ? tss_pkg::SC_RX_ACK : tss_pkg::SC_RX_NACK;
                if (!ackd)
                  mode <= tss_pkg::M_IDLE;
              end
              tss_pkg::M_TX: begin
                if (!mack)
                  status <= tss_pkg::SC_TX_NACK;
                else
                  status <= last ? tss_pkg::SC_LAST_ACK : tss_pkg::SC_TX_ACK;
                if (last || !mack)
                  mode <= tss_pkg::M_IDLE;
              end
              tss_pkg::M_IDLE: mode <= tss_pkg::M_IDLE;
            endcase
          end
        end
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_gc_ack;
    en && !start && !stop && fall && bi == 4'h8 && mode == tss_pkg::M_RX && gc && ackd
      |=> flag && status == tss_pkg::SC_GC_ACK;
  endproperty
  a_gc_ack: assert property (p_gc_ack) else $error("gc ack status wrong");

  property p_gc_nack;
    en && !start && !stop && fall && bi == 4'h8 && mode == tss_pkg::M_RX && gc && !ackd
      |=> status == tss_pkg::SC_GC_NACK && mode == tss_pkg::M_IDLE;
  endproperty
  a_gc_nack: assert property (p_gc_nack) else $error("gc nack not unaddressed");

  property p_stop;
    en && (start || stop) && mode == tss_pkg::M_RX
      |=> flag && status == tss_pkg::SC_STOP && mode != tss_pkg::M_RX;
  endproperty
  a_stop: assert property (p_stop) else $error("stop while addressed missed");

  property p_isolate;
    en && !ack_en && !start && !stop && fall && bi == 4'h7 && mode == tss_pkg::M_ADDR
      |=> !sda_oe && mode == tss_pkg::M_IDLE ##1 !sda_oe;
  endproperty
  a_isolate: assert property (p_isolate) else $error("acked with ack disabled");

  property p_hold;
    flag && scl_oe && !clr && en |=> scl_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("clock released with flag set");

  property p_release;
    clr && !fall && !start && !stop |=> !scl_oe && !flag;
  endproperty
  a_release: assert property (p_release) else $error("clock not released on clear");

  property p_last;
    en && !start && !stop && fall && bi == 4'h8 && mode == tss_pkg::M_TX && last
      |=> mode == tss_pkg::M_IDLE && !sda_oe &&
          (status == tss_pkg::SC_LAST_ACK || status == tss_pkg::SC_TX_NACK);
  endproperty
  a_last: assert property (p_last) else $error("last byte end wrong");

  property p_read_addr;
    en && !start && !stop && fall && bi == 4'h8 && mode == tss_pkg::M_ADDR && rd && !arb_lost
      |=> mode == tss_pkg::M_TX && status == tss_pkg::SC_OWN_R && scl_oe;
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("read address status wrong");

  property p_write_addr;
    en && !start && !stop && fall && bi == 4'h8 && mode == tss_pkg::M_ADDR && !rd && !gc
      && !arb_lost |=> mode == tss_pkg::M_RX && status == tss_pkg::SC_OWN_W;
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("write address status wrong");
endmodule

// >>> tss_pkg.sv
// shared constants and types for the two-wire slave state engine
package tss_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_ADDR = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_DATA = 4'hC;
  // reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // serial_control bit positions
  localparam int CB_INT = 7;
  localparam int CB_ACK = 6;
  localparam int CB_STA = 5;
  localparam int CB_STO = 4;
  localparam int CB_WC = 3;
  localparam int CB_EN = 2;
  localparam int CB_IE = 0;
  // bit slots within one byte frame
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // status codes, prescaler bits always zero
  localparam logic [7:0] SC_OWN_W = 8'h60;
  localparam logic [7:0] SC_ARB_W = 8'h68;
  localparam logic [7:0] SC_GC_W = 8'h70;
  localparam logic [7:0] SC_ARB_GC = 8'h78;
  localparam logic [7:0] SC_RX_ACK = 8'h80;
  localparam logic [7:0] SC_RX_NACK = 8'h88;
  localparam logic [7:0] SC_GC_ACK = 8'h90;
  localparam logic [7:0] SC_GC_NACK = 8'h98;
  localparam logic [7:0] SC_STOP = 8'hA0;
  localparam logic [7:0] SC_OWN_R = 8'hA8;
  localparam logic [7:0] SC_ARB_R = 8'hB0;
  localparam logic [7:0] SC_TX_ACK = 8'hB8;
  localparam logic [7:0] SC_TX_NACK = 8'hC0;
  localparam logic [7:0] SC_LAST_ACK = 8'hC8;
  localparam logic [7:0] SC_NONE = 8'hF8;
  // bus responses
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ADDR = 2'b01,
    M_RX = 2'b10,
    M_TX = 2'b11
  } tss_mode_t;
endpackage

// >>> tss_master.sv
// behavioural two-wire bus master that drives the slave from the far side
`timescale 1ns/10ps
module tss_master (
  // wire levels as seen on the bus
  input wire logic scl,
  input wire logic sda,
  // master pull-downs, high while pulling low
  output logic scl_pd,
  output logic sda_pd
);
  // half of the 160 ns link clock period
  localparam int HALF = 80;
  initial begin
    scl_pd = 1'b0;
    sda_pd = 1'b0;
  end
  // release scl and wait out a stretch; bounded so a stuck slave cannot hang us
  task automatic hi();
    scl_pd = 1'b0;
    for (int i = 0; i < 4000 && scl !== 1'b1; i++) #10;
    #HALF;
  endtask
  // one bit slot: data changes only while scl is low
  task automatic bit_slot(input logic b, output logic got);
    sda_pd = ~b;
    #HALF;
    hi();
    got = sda;
    scl_pd = 1'b1;
  endtask
  // start from an idle bus
  task automatic start();
    sda_pd = 1'b0;
    hi();
    sda_pd = 1'b1;
    #HALF;
    scl_pd = 1'b1;
  endtask
  // stop, leaving both lines released so the pull-ups win
  task automatic stop();
    sda_pd = 1'b1;
    #HALF;
    hi();
    sda_pd = 1'b0;
    #HALF;
  endtask
  // byte out msb first, then sample the slave's ack
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], g);
    bit_slot(1'b1, ack);
  endtask
  // byte in msb first, then our ack (0) or nack (1)
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(nack, g);
  endtask
endmodule

// >>> tss_slave_test.sv
// self-checking bench for the two-wire slave state engine
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tss_slave_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, arb_lost, sleep_req;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, v, rng;
  logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, wake, start_when_free;
  logic scl_o, sda_o;
  logic [1:0] bresp, rresp, last_resp;
  logic m_scl, m_sda, a;
  logic [7:0] d, d2, g;
  logic [6:0] sa;
  int errors = 0;
  int comparisons = 0;
  // open-drain wires with pull-ups: low if anyone pulls
  wire logic scl = ~(scl_oe | m_scl);
  wire logic sda = ~(sda_oe | m_sda);
  tss_slave DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .arb_lost(arb_lost), .sleep_req(sleep_req), .wake(wake),
    .start_when_free(start_when_free));
  tss_master m (.scl(scl), .sda(sda), .scl_pd(m_scl), .sda_pd(m_sda));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // status expected after a transmitted byte
  function automatic logic [7:0] exp_tx(input logic mnack, input logic last);
    if (mnack) return tss_pkg::SC_TX_NACK;
    return last ? tss_pkg::SC_LAST_ACK : tss_pkg::SC_TX_ACK;
  endfunction
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // axi write: address and data offered together, each dropped when taken
  // waits for the answer however long it takes; only the watchdog ends a hang
  task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= 32'(dt);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    last_resp = bresp;
  endtask
  task automatic rd(input logic [3:0] ad, output logic [31:0] dt);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    dt = rdata;
    last_resp = rresp;
  endtask
  // poll the flag (bounded), then compare the status code
  task automatic st(input logic [7:0] e);
    logic [31:0] x;
    int n;
    n = 0;
    do begin
      rd(tss_pkg::OFS_CTRL, x);
      n++;
    end while (x[tss_pkg::CB_INT] !== 1'b1 && n < 100);
    rd(tss_pkg::OFS_STAT, x);
    `CHK(x[7:0], e)
  endtask
  // clear the flag while keeping the unit enabled
  task automatic clr(input logic ack);
    wr(tss_pkg::OFS_CTRL, {1'b1, ack, 6'h04});
  endtask
  // watchdog sized well above the whole sequence
  initial begin
    #1_000_000;
    errors++;
    finish_test();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, arb_lost, sleep_req, aresetn} = 8'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'h1;
    rng = 32'h0000_5769;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), v);
      `CHK(v, (i == 2) ? 32'h0000_00F8 : 32'h0000_0000)
    end
    rd(4'h2, v);
    `CHK(last_resp, tss_pkg::RESP_ERR)
    `CHK({scl_o, sda_o}, 2'b00)
    // data write with the flag clear collides and must not land
    wr(tss_pkg::OFS_DATA, 8'h5A);
    rd(tss_pkg::OFS_CTRL, v);
    `CHK(v[tss_pkg::CB_WC], 1'b1)
    rd(tss_pkg::OFS_DATA, v);
    `CHK(v[7:0], tss_pkg::DATA_RST)
    rng = xs(rng);
    sa = rng[6:0] | 7'h01; // never zero, so it cannot alias general call
    wr(tss_pkg::OFS_ADDR, {sa, 1'b1});
    wr(tss_pkg::OFS_CTRL, 8'h44);
    rd(tss_pkg::OFS_ADDR, v);
    `CHK(v[7:0], {sa, 1'b1})
    // own address, one data byte, then stop while addressed
    m.start();
    m.wbyte({sa, 1'b0}, a);
    `CHK(a, 1'b0)
    st(tss_pkg::SC_OWN_W);
    `CHK(scl_oe, 1'b1)
    rng = xs(rng);
    d = rng[7:0];
    clr(1'b1);
    m.wbyte(d, a);
    st(tss_pkg::SC_RX_ACK);
    clr(1'b1);
    m.stop();
    st(tss_pkg::SC_STOP);
    clr(1'b1);
    // general call: acked byte, then nacked byte after enable cleared
    m.start();
    m.wbyte(8'h00, a);
    st(tss_pkg::SC_GC_W);
    clr(1'b1);
    m.wbyte(d, a);
    `CHK(a, 1'b0)
    st(tss_pkg::SC_GC_ACK);
    rd(tss_pkg::OFS_DATA, v);
    `CHK(v[7:0], d)
    clr(1'b0);
    m.wbyte(~d, a);
    `CHK(a, 1'b1)
    st(tss_pkg::SC_GC_NACK);
    clr(1'b1);
    m.stop();
    rd(tss_pkg::OFS_STAT, v);
    `CHK(v[7:0], tss_pkg::SC_NONE)
    // refusals: gc disabled, ack disabled, gc with read direction
    for (int k = 0; k < 3; k++) begin
      wr(tss_pkg::OFS_ADDR, {sa, k != 0});
      wr(tss_pkg::OFS_CTRL, (k == 1) ? 8'h04 : 8'h44);
      m.start();
      m.wbyte((k == 1) ? {sa, 1'b0} : {7'h00, k == 2}, a);
      m.stop();
      `CHK(a, 1'b1)
    end
    // transmit, plain then after lost arbitration; last byte or master nack
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      arb_lost <= k[0];
      m.start();
      m.wbyte({sa, 1'b1}, a);
      `CHK(a, 1'b0)
      st(k[0] ? tss_pkg::SC_ARB_R : tss_pkg::SC_OWN_R);
      rng = xs(rng);
      d = rng[7:0];
      d2 = rng[15:8];
      wr(tss_pkg::OFS_DATA, d);
      clr(1'b1);
      m.rbyte(1'b0, g);
      `CHK(g, d)
      st(exp_tx(1'b0, 1'b0));
      wr(tss_pkg::OFS_DATA, d2);
      clr(k[0]);
      m.rbyte(k[0], g);
      `CHK(g, d2)
      st(exp_tx(k[0], ~k[0]));
      clr(1'b1);
      m.rbyte(1'b1, g);
      `CHK(g, 8'hFF)
      m.stop();
    end
    // wake from sleep: clock held until the flag is cleared
    @(posedge aclk);
    arb_lost <= 1'b0;
    sleep_req <= 1'b1;
    m.start();
    m.wbyte({sa, 1'b0}, a);
    repeat (8) @(posedge aclk);
    `CHK(wake, 1'b1)
    `CHK(scl_oe, 1'b1)
    st(tss_pkg::SC_OWN_W);
    clr(1'b1);
    @(posedge aclk);
    `CHK(scl_oe, 1'b0)
    sleep_req <= 1'b0;
    m.stop();
    st(tss_pkg::SC_STOP);
    clr(1'b1);
    // start request queued while the bus is free
    wr(tss_pkg::OFS_CTRL, 8'h64);
    repeat (4) @(posedge aclk);
    `CHK(start_when_free, 1'b1)
    wr(tss_pkg::OFS_CTRL, 8'h44);
    finish_test();
  end
endmodule
